// >>> verilog/ffx_regs.svh
`ifndef FFX_REGS_SVH
`define FFX_REGS_SVH

// register byte offsets on the avalon slave
`define FFX_ADDR_W        5
`define FFX_REG_CTRL      5'h00
`define FFX_REG_CMD       5'h04
`define FFX_REG_WDATA     5'h08
`define FFX_REG_RDATA     5'h0c
`define FFX_REG_STATUS    5'h10

// control fields
`define FFX_CTRL_CASCADE  0
`define FFX_CTRL_LEAD     1
`define FFX_CTRL_RESET    2'h2

// command fields (write one to start)
`define FFX_CMD_RESET     0
`define FFX_CMD_REPLAY    1
`define FFX_CMD_READ      2

// status fields
`define FFX_ST_BUSY       0
`define FFX_ST_SINGLE     1
`define FFX_ST_HALF       2
`define FFX_ST_EMPTY      3
`define FFX_ST_FULL       4
`define FFX_ST_ERR_FULL   5
`define FFX_ST_ERR_EMPTY  6
`define FFX_ST_ERR_REPLAY 7
`define FFX_ST_COUNT_LSB  16

// array geometry
`define FFX_DEPTH         2048
`define FFX_WIDTH         9

// strobe timing in ns and derived cycle counts (least times round up)
`define FFX_CLK_NS        100
`define FFX_T_PULSE_NS    200
`define FFX_T_ACCESS_NS   200
`define FFX_T_RECOV_NS    35
`define FFX_T_RSTSET_NS   180
`define FFX_CYC(ns)       (((ns) + `FFX_CLK_NS - 1) / `FFX_CLK_NS)
`define FFX_PULSE_CYC     `FFX_CYC(`FFX_T_PULSE_NS)
`define FFX_READ_CYC      `FFX_CYC(`FFX_T_ACCESS_NS)
`define FFX_RECOV_CYC     `FFX_CYC(`FFX_T_RECOV_NS)
`define FFX_RSTLOW_CYC    `FFX_CYC(`FFX_T_RSTSET_NS)

`endif

// >>> verilog/ffx_pkg.sv
`default_nettype none
package ffx_pkg;
  // sequencer states, one-hot
  typedef enum logic [4:0] {
    FFX_ST_IDLE   = 5'h01,
    FFX_ST_CLEAR  = 5'h02,
    FFX_ST_WRITE  = 5'h04,
    FFX_ST_READ   = 5'h08,
    FFX_ST_REPLAY = 5'h10
  } ffx_state_type;
endpackage
`default_nettype wire

// >>> verilog/ffx_strobe.sv
`default_nettype none
module ffx_strobe #(
  parameter int LOW_CYC = 2,
  parameter int REC_CYC = 1
) (
  input  wire logic sys_clk_in,
  input  wire logic srst_in,
  input  wire logic start_in,
  output logic      strobe_n_out,
  output logic      sample_out,
  output logic      done_out,
  output logic      busy_out
);
  localparam int CW = $clog2(LOW_CYC + REC_CYC + 1);

  logic          low_r;
  logic          rec_r;
  logic [CW-1:0] cnt_r;

  // low phase then recovery phase; a start while busy is dropped
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      low_r <= 1'b0;
      rec_r <= 1'b0;
      cnt_r <= '0;
    end else if (start_in && !busy_out) begin
      low_r <= 1'b1;
      cnt_r <= CW'(LOW_CYC - 1);
    end else if (low_r) begin
      if (cnt_r == '0) begin
        low_r <= 1'b0;
        rec_r <= 1'b1;
        cnt_r <= CW'(REC_CYC - 1);
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
    end else if (rec_r) begin
      if (cnt_r == '0) begin
        rec_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // strobe is a direct flop image, no glitches on the pin
  assign strobe_n_out = ~low_r;
  assign sample_out   = low_r && (cnt_r == '0);
  assign done_out     = rec_r && (cnt_r == '0);
  assign busy_out     = low_r | rec_r;
endmodule
`default_nettype wire

// >>> verilog/ffx_host.sv
// Contract
// [RULE_01] replay only below 2048 writes since reset
// [RULE_02] never replay in depth cascade
// [RULE_03] token input low at reset: single mode
// [RULE_04] widen by sharing controls across devices
// [RULE_05] flags readable from any width member
// [RULE_06] half flag unchanged in width groups
// [RULE_07] half flag falls on next write
// [RULE_08] half flag rises on read to half
// [RULE_09] composite flags combine all device flags
// [RULE_10] lead select low at reset: first
// [RULE_11] lead select high at reset: others
// [RULE_12] token out feeds next token in
// [RULE_13] half flag disabled in cascade mode
// [RULE_14] token pulse mirrors causing strobe
// [RULE_15] token pulses on last location access
// [RULE_16] flags follow pointer distance, not address
// [RULE_17] lead device works without token
// [RULE_18] non-lead writes after first token
// [RULE_19] non-lead reads after second token
// [RULE_20] token precedes the strobe it enables
// [RULE_21] width and depth may combine
// [RULE_22] writer watches full, reader watches empty
// [RULE_23] bidirectional pairs may expand
// [RULE_24] replay rewinds read pointer only
// [RULE_25] reset clears both pointers
// [RULE_26] pointers wrap, flags from distance
// [RULE_27] strobes ignored while full or empty
// [RULE_28] half compare uses modulo difference
`include "ffx_regs.svh"
`default_nettype none
module ffx_host #(
  parameter int DEPTH = `FFX_DEPTH,
  parameter int WIDTH = `FFX_WIDTH
) (
  input  wire logic                   sys_clk_in,
  input  wire logic                   srst_in,
  input  wire logic [`FFX_ADDR_W-1:0] avs_address_in,
  input  wire logic                   avs_read_in,
  input  wire logic                   avs_write_in,
  input  wire logic [31:0]            avs_writedata_in,
  output logic [31:0]                 avs_readdata_out,
  output logic                        avs_waitrequest_out,
  output logic                        write_strobe_n_out,
  output logic                        read_strobe_n_out,
  output logic                        pointer_clear_n_out,
  output logic                        replay_lead_n_out,
  output logic                        chain_token_in_n_out,
  output logic [WIDTH-1:0]            fifo_data_out,
  input  wire logic [WIDTH-1:0]       fifo_data_in,
  input  wire logic                   capacity_flag_n_in,
  input  wire logic                   drained_flag_n_in,
  input  wire logic                   half_level_flag_n_in,
  output logic                        state_dbg_out
);
  import ffx_pkg::*;

  localparam int CNTW = $clog2(DEPTH) + 1;

  ffx_state_type   state_r;
  logic [1:0]      ctrl_r;
  logic            cascade_act_r;
  logic            lead_act_r;
  logic [3:0]      go_r;
  logic [WIDTH-1:0] wdata_r;
  logic [WIDTH-1:0] rdata_r;
  logic [CNTW-1:0] written_r;
  logic            err_full_r;
  logic            err_empty_r;
  logic            err_replay_r;
  logic            rd_ack_r;
  logic [31:0]     readdata_r;
  logic [31:0]     status_w;
  logic            busy_w;
  logic            cmd_sel_w;
  logic            wdata_sel_w;
  logic            wr_take_w;
  logic            half_w;
  logic            clr_busy;
  logic            clr_done;
  logic            wr_busy;
  logic            wr_done;
  logic            rd_busy;
  logic            rd_done;
  logic            rd_sample;
  logic            rp_busy;
  logic            rp_done;
  logic            clear_n_w;
  logic            replay_n_w;
  logic            req_reset_w;
  logic            req_replay_w;
  logic            req_read_w;
  logic            req_write_w;
  logic            replay_ok_w;

  // go_r bits: 0 clear, 1 write, 2 read, 3 replay; one strobe set may feed a width group [RULE_04] [RULE_21] [RULE_23]
  ffx_strobe #(.LOW_CYC(`FFX_RSTLOW_CYC), .REC_CYC(`FFX_RECOV_CYC)) u_clear (
    .sys_clk_in   (sys_clk_in),
    .srst_in      (srst_in),
    .start_in     (go_r[0]),
    .strobe_n_out (clear_n_w),
    .sample_out   (),
    .done_out     (clr_done),
    .busy_out     (clr_busy)
  );
  ffx_strobe #(.LOW_CYC(`FFX_PULSE_CYC), .REC_CYC(`FFX_RECOV_CYC)) u_write (
    .sys_clk_in   (sys_clk_in),
    .srst_in      (srst_in),
    .start_in     (go_r[1]),
    .strobe_n_out (write_strobe_n_out),
    .sample_out   (),
    .done_out     (wr_done),
    .busy_out     (wr_busy)
  );
  ffx_strobe #(.LOW_CYC(`FFX_READ_CYC), .REC_CYC(`FFX_RECOV_CYC)) u_read (
    .sys_clk_in   (sys_clk_in),
    .srst_in      (srst_in),
    .start_in     (go_r[2]),
    .strobe_n_out (read_strobe_n_out),
    .sample_out   (rd_sample),
    .done_out     (rd_done),
    .busy_out     (rd_busy)
  );
  ffx_strobe #(.LOW_CYC(`FFX_PULSE_CYC), .REC_CYC(`FFX_RECOV_CYC)) u_replay (
    .sys_clk_in   (sys_clk_in),
    .srst_in      (srst_in),
    .start_in     (go_r[3]),
    .strobe_n_out (replay_n_w),
    .sample_out   (),
    .done_out     (rp_done),
    .busy_out     (rp_busy)
  );

  // bus decode; command registers stall the master while a strobe runs
  assign busy_w       = (state_r != FFX_ST_IDLE);
  assign cmd_sel_w    = (avs_address_in == `FFX_REG_CMD);
  assign wdata_sel_w  = (avs_address_in == `FFX_REG_WDATA);
  assign wr_take_w    = avs_write_in && !avs_waitrequest_out;
  assign avs_waitrequest_out = (avs_write_in && (cmd_sel_w || wdata_sel_w) && busy_w) ||
                               (avs_read_in && !rd_ack_r);
  assign req_reset_w  = wr_take_w && cmd_sel_w && avs_writedata_in[`FFX_CMD_RESET];
  assign req_replay_w = wr_take_w && cmd_sel_w && avs_writedata_in[`FFX_CMD_REPLAY] && !req_reset_w;
  assign req_read_w   = wr_take_w && cmd_sel_w && avs_writedata_in[`FFX_CMD_READ] &&
                        !req_reset_w && !avs_writedata_in[`FFX_CMD_REPLAY];
  assign req_write_w  = wr_take_w && wdata_sel_w;
  // the array holds 2048 words; later writes overwrite what replay would resend
  assign replay_ok_w  = !cascade_act_r && (written_r < CNTW'(DEPTH)); // [RULE_01] [RULE_02]

  // sequencer: one operation at a time, a refused command leaves it idle
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state_r <= FFX_ST_CLEAR;
      go_r    <= 4'h1;
    end else begin
      go_r <= 4'h0;
      case (state_r)
        FFX_ST_IDLE: begin
          if (req_reset_w) begin
            state_r <= FFX_ST_CLEAR;
            go_r    <= 4'h1;
          end else if (req_write_w && capacity_flag_n_in) begin // [RULE_22]
            state_r <= FFX_ST_WRITE;
            go_r    <= 4'h2;
          end else if (req_read_w && drained_flag_n_in) begin // [RULE_22]
            state_r <= FFX_ST_READ;
            go_r    <= 4'h4;
          end else if (req_replay_w && replay_ok_w) begin
            state_r <= FFX_ST_REPLAY;
            go_r    <= 4'h8;
          end
        end
        FFX_ST_CLEAR:  if (clr_done) state_r <= FFX_ST_IDLE;
        FFX_ST_WRITE:  if (wr_done) state_r <= FFX_ST_IDLE;
        FFX_ST_READ:   if (rd_done) state_r <= FFX_ST_IDLE;
        FFX_ST_REPLAY: if (rp_done) state_r <= FFX_ST_IDLE;
        default: begin
          state_r <= FFX_ST_IDLE;
        end
      endcase
    end
  end

  // control register; mode and lead choice act only at the next clear
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      ctrl_r <= `FFX_CTRL_RESET;
    end else if (wr_take_w && avs_address_in == `FFX_REG_CTRL) begin
      ctrl_r <= avs_writedata_in[1:0];
    end
  end

  // latch mode at the start of a clear so the straps hold for its whole length
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      cascade_act_r <= 1'b0;
      lead_act_r    <= 1'b1;
    end else if (go_r[0]) begin
      cascade_act_r <= ctrl_r[`FFX_CTRL_CASCADE];
      lead_act_r    <= ctrl_r[`FFX_CTRL_LEAD];
    end
  end

  // straps: token input grounded for single mode, shared pin carries lead select
  assign pointer_clear_n_out  = clear_n_w; // [RULE_25]
  assign chain_token_in_n_out = cascade_act_r; // [RULE_03] [RULE_12] [RULE_20]
  // replay and lead select share one pin; during clear it is the strap
  assign replay_lead_n_out    = clr_busy ? !(cascade_act_r && lead_act_r) : replay_n_w; // [RULE_10] [RULE_11]

  // write data is held from acceptance until the next write
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      wdata_r <= '0;
    end else if (req_write_w && state_r == FFX_ST_IDLE) begin
      wdata_r <= avs_writedata_in[WIDTH-1:0];
    end
  end
  assign fifo_data_out = wdata_r;

  // read data taken at the last low cycle, after the access time
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      rdata_r <= '0;
    end else if (rd_sample) begin
      rdata_r <= fifo_data_in;
    end
  end

  // writes since the last clear, saturating at the array depth
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || go_r[0]) begin
      written_r <= '0;
    end else if (go_r[1] && written_r < CNTW'(DEPTH)) begin
      written_r <= written_r + 1'b1;
    end
  end

  // sticky refusals; a new refusal wins over a same-cycle clear
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      err_full_r   <= 1'b0;
      err_empty_r  <= 1'b0;
      err_replay_r <= 1'b0;
    end else begin
      if (req_write_w && !capacity_flag_n_in && !busy_w) begin
        err_full_r <= 1'b1;
      end else if (wr_take_w && avs_address_in == `FFX_REG_STATUS && avs_writedata_in[`FFX_ST_ERR_FULL]) begin
        err_full_r <= 1'b0;
      end
      if (req_read_w && !drained_flag_n_in && !busy_w) begin
        err_empty_r <= 1'b1;
      end else if (wr_take_w && avs_address_in == `FFX_REG_STATUS && avs_writedata_in[`FFX_ST_ERR_EMPTY]) begin
        err_empty_r <= 1'b0;
      end
      if (req_replay_w && !replay_ok_w && !busy_w) begin
        err_replay_r <= 1'b1;
      end else if (wr_take_w && avs_address_in == `FFX_REG_STATUS && avs_writedata_in[`FFX_ST_ERR_REPLAY]) begin
        err_replay_r <= 1'b0;
      end
    end
  end

  // half flag is only meaningful in single mode; the pin is the token in cascade
  assign half_w = !cascade_act_r && !half_level_flag_n_in; // [RULE_13] [RULE_07] [RULE_08]

  always_comb begin
    status_w                        = 32'h0;
    status_w[`FFX_ST_BUSY]          = busy_w;
    status_w[`FFX_ST_SINGLE]        = !cascade_act_r;
    status_w[`FFX_ST_HALF]          = half_w;
    status_w[`FFX_ST_EMPTY]         = !drained_flag_n_in; // [RULE_05] [RULE_09]
    status_w[`FFX_ST_FULL]          = !capacity_flag_n_in; // [RULE_05] [RULE_09]
    status_w[`FFX_ST_ERR_FULL]      = err_full_r;
    status_w[`FFX_ST_ERR_EMPTY]     = err_empty_r;
    status_w[`FFX_ST_ERR_REPLAY]    = err_replay_r;
    status_w[`FFX_ST_COUNT_LSB +: CNTW] = written_r;
  end

  // reads answer one cycle late so the data comes from a flop
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      rd_ack_r   <= 1'b0;
      readdata_r <= 32'h0;
    end else begin
      rd_ack_r <= avs_read_in && !rd_ack_r;
      if (avs_read_in && !rd_ack_r) begin
        case (avs_address_in)
          `FFX_REG_CTRL:   readdata_r <= {30'h0, ctrl_r};
          `FFX_REG_RDATA:  readdata_r <= {{(32 - WIDTH){1'b0}}, rdata_r};
          `FFX_REG_STATUS: readdata_r <= status_w;
          default:         readdata_r <= 32'h0;
        endcase
      end
    end
  end
  assign avs_readdata_out = readdata_r;
  assign state_dbg_out    = busy_w;

  AST_SINGLE_TOKEN_LOW: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE_03]
    (!pointer_clear_n_out && !ctrl_r[`FFX_CTRL_CASCADE] && $past(go_r[0])) |-> !chain_token_in_n_out)
    else $error("token input not low while clearing in single mode");
  AST_LEAD_LOW: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE_10]
    (!pointer_clear_n_out && cascade_act_r && lead_act_r) |-> !replay_lead_n_out)
    else $error("lead select not low on lead device clear");
  AST_FOLLOWER_HIGH: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE_11]
    (!pointer_clear_n_out && cascade_act_r && !lead_act_r) |-> replay_lead_n_out)
    else $error("lead select not high on follower clear");
  AST_NO_CASCADE_REPLAY: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE_02]
    $fell(replay_lead_n_out) && pointer_clear_n_out |-> !cascade_act_r)
    else $error("replay issued in cascade mode");
  AST_REPLAY_BELOW_DEPTH: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE_01]
    go_r[3] |-> $past(written_r) < CNTW'(DEPTH))
    else $error("replay issued after a full depth of writes");
  AST_WRITE_NOT_FULL: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE_22]
    go_r[1] |-> $past(capacity_flag_n_in) ##1 !write_strobe_n_out[*2] ##1 write_strobe_n_out)
    else $error("write strobe while full or wrong width");
  AST_READ_NOT_EMPTY: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE_22]
    go_r[2] |-> $past(drained_flag_n_in) ##1 !read_strobe_n_out ##2 rdata_r == $past(fifo_data_in, 1))
    else $error("read strobe while empty or data not captured");
  AST_HALF_MASKED: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE_13]
    cascade_act_r |-> !status_w[`FFX_ST_HALF])
    else $error("half flag reported in cascade mode");

  COV_WRITE: cover property (@(posedge sys_clk_in) disable iff (srst_in) go_r[1] ##[1:4] wr_done);
  COV_READ: cover property (@(posedge sys_clk_in) disable iff (srst_in) go_r[2] ##[1:4] rd_done);
  COV_REPLAY: cover property (@(posedge sys_clk_in) disable iff (srst_in) go_r[3] ##[1:4] rp_done);
  COV_CASCADE_LEAD: cover property (@(posedge sys_clk_in) disable iff (srst_in)
    !pointer_clear_n_out && cascade_act_r && lead_act_r);
endmodule
`default_nettype wire

// >>> tb/ffx_dev_model.sv
`default_nettype none
// behavioural fifo device: reacts to strobe and token edges only, no clock of its own
module ffx_dev_model #(
  parameter int DEPTH = 2048,
  parameter int WIDTH = 9
) (
  input  wire logic             write_strobe_n_in,
  input  wire logic             read_strobe_n_in,
  input  wire logic             pointer_clear_n_in,
  input  wire logic             replay_lead_n_in,
  input  wire logic             chain_token_in_n_in,
  input  wire logic [WIDTH-1:0] data_in,
  output logic [WIDTH-1:0]      data_out,
  output logic                  capacity_flag_n_out,
  output logic                  drained_flag_n_out,
  output logic                  half_level_flag_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [WIDTH-1:0] mem [DEPTH];
  int unsigned      wr_ptr_r;
  int unsigned      rd_ptr_r;
  int unsigned      count_r;
  int unsigned      tokens_r;
  logic             single_r;
  logic             lead_r;
  logic             wr_ok_r;
  logic             rd_ok_r;

  initial begin
    {wr_ptr_r, rd_ptr_r, count_r, tokens_r} = '0;
    {single_r, lead_r, wr_ok_r, rd_ok_r} = 4'h8;
    data_out = '0;
    half_level_flag_n_out = 1'b1;
  end

  // flags come from the unread count, never from absolute addresses
  assign capacity_flag_n_out = (count_r != DEPTH);
  assign drained_flag_n_out  = (count_r != 0);

  // clear holds both pointers at zero; mode pins latched on release
  always @(pointer_clear_n_in) begin
    if (!pointer_clear_n_in) begin
      {wr_ptr_r, rd_ptr_r, count_r, tokens_r} = '0;
      half_level_flag_n_out = 1'b1;
    end else begin
      single_r = !chain_token_in_n_in;
      lead_r   = !replay_lead_n_in;
    end
  end

  // a follower counts ring token pulses: writes after one, reads after two
  always @(negedge chain_token_in_n_in) begin
    if (pointer_clear_n_in && !single_r) tokens_r++;
  end

  // write starts on the falling strobe, unless full or still waiting for a token
  always @(negedge write_strobe_n_in) begin
    wr_ok_r = pointer_clear_n_in && capacity_flag_n_out && (single_r || lead_r || tokens_r > 0);
    if (wr_ok_r) begin
      // in cascade the shared pin mirrors the strobe on the last physical location
      if (!single_r && wr_ptr_r == DEPTH - 1) half_level_flag_n_out = 1'b0;
      count_r++;
      if (single_r && count_r > DEPTH / 2) half_level_flag_n_out = 1'b0;
    end
  end

  // data is latched at the rising strobe, where setup is specified
  always @(posedge write_strobe_n_in) begin
    if (wr_ok_r) begin
      mem[wr_ptr_r] = data_in;
      wr_ptr_r = (wr_ptr_r + 1) % DEPTH;
    end
    if (!single_r) half_level_flag_n_out = 1'b1;
    wr_ok_r = 1'b0;
  end

  always @(negedge read_strobe_n_in) begin
    rd_ok_r = pointer_clear_n_in && drained_flag_n_out && (single_r || lead_r || tokens_r > 1);
    if (rd_ok_r) begin
      data_out = mem[rd_ptr_r];
      if (!single_r && rd_ptr_r == DEPTH - 1) half_level_flag_n_out = 1'b0;
    end
  end

  // bus released after a read: inverted last value so stale data never matches
  always @(posedge read_strobe_n_in) begin
    if (rd_ok_r) begin
      rd_ptr_r = (rd_ptr_r + 1) % DEPTH;
      count_r--;
      if (count_r <= DEPTH / 2) half_level_flag_n_out = 1'b1;
    end
    if (!single_r) half_level_flag_n_out = 1'b1;
    data_out = ~data_out;
    rd_ok_r = 1'b0;
  end

  // replay rewinds the read side only; valid only before any wrap
  always @(negedge replay_lead_n_in) begin
    if (pointer_clear_n_in) begin
      rd_ptr_r = 0;
      count_r  = wr_ptr_r;
    end
  end
endmodule
`default_nettype wire

// >>> tb/ffx_host_test.sv
`include "ffx_regs.svh"
`default_nettype none
module ffx_host_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   sys_clk_in;
  logic                   srst_in;
  logic [`FFX_ADDR_W-1:0] avs_address_in;
  logic                   avs_read_in;
  logic                   avs_write_in;
  logic [31:0]            avs_writedata_in;
  logic [31:0]            avs_readdata_out;
  logic                   avs_waitrequest_out;
  logic [31:0]            rd_w;
  logic                   dbg;
  logic                   wr_n, rd_n, clr_n, rl_n, xi_n, full_n, empty_n, half_n;
  logic [8:0]             dev_d, dev_q;
  int                     miscompares, samples_checked, cycles, wr_falls, rd_falls;

  ffx_host ffx_host_i (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .write_strobe_n_out(wr_n), .read_strobe_n_out(rd_n), .pointer_clear_n_out(clr_n),
    .replay_lead_n_out(rl_n), .chain_token_in_n_out(xi_n), .fifo_data_out(dev_d), .fifo_data_in(dev_q),
    .capacity_flag_n_in(full_n), .drained_flag_n_in(empty_n), .half_level_flag_n_in(half_n), .state_dbg_out(dbg));

  ffx_dev_model ffx_dev_model_i (.write_strobe_n_in(wr_n), .read_strobe_n_in(rd_n), .pointer_clear_n_in(clr_n),
    .replay_lead_n_in(rl_n), .chain_token_in_n_in(xi_n), .data_in(dev_d), .data_out(dev_q),
    .capacity_flag_n_out(full_n), .drained_flag_n_out(empty_n), .half_level_flag_n_out(half_n));

  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  // strobe counters show whether a refused request reached the pins
  always @(negedge wr_n) wr_falls++;
  always @(negedge rd_n) rd_falls++;

  // hang guard: the full fill and drain needs roughly half of this
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low, released at that edge
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= 1'b1;
    do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
    avs_write_in <= 1'b0;
  endtask

  task automatic bus_rd(input logic [4:0] a);
    @(posedge sys_clk_in);
    avs_address_in <= a;
    avs_read_in <= 1'b1;
    do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
    rd_w = avs_readdata_out;
    avs_read_in <= 1'b0;
  endtask

  task automatic cmd(input logic [31:0] c);
    bus_wr(`FFX_REG_CMD, c);
    do bus_rd(`FFX_REG_STATUS); while (rd_w[0] !== 1'b0);
  endtask

  task automatic st_chk(input logic [31:0] exp);
    bus_rd(`FFX_REG_STATUS);
    chk32(rd_w & 32'h0000_00ff, exp);
  endtask

  task automatic fifo_wr(input logic [8:0] d);
    bus_wr(`FFX_REG_WDATA, {23'h0, d});
    do bus_rd(`FFX_REG_STATUS); while (rd_w[0] !== 1'b0);
  endtask

  task automatic fifo_rd(input logic [8:0] exp);
    cmd(32'h4);
    bus_rd(`FFX_REG_RDATA);
    chk32(rd_w, {23'h0, exp});
  endtask

  initial begin
    int n;
    srst_in = 1'b1;
    {avs_address_in, avs_read_in, avs_write_in, avs_writedata_in} = '0;
    repeat (16) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    do bus_rd(`FFX_REG_STATUS); while (rd_w[0] !== 1'b0);
    chk1(dbg, 1'b0);
    bus_rd(`FFX_REG_CTRL);
    chk32(rd_w, 32'h2);
    st_chk(32'h0a);
    chk1(xi_n, 1'b0);
    bus_wr(5'h14, 32'hffff_ffff);
    bus_rd(5'h14);
    chk32(rd_w, 32'h0);
    // read while empty is refused with no strobe
    cmd(32'h4);
    st_chk(32'h4a);
    chk32(32'(rd_falls), 32'h0);
    bus_wr(`FFX_REG_STATUS, 32'h40);
    // order, then replay from the first location
    fifo_wr(9'h1a5);
    fifo_wr(9'h05a);
    fifo_wr(9'h100);
    fifo_rd(9'h1a5);
    fifo_rd(9'h05a);
    cmd(32'h2);
    fifo_rd(9'h1a5);
    fifo_rd(9'h05a);
    fifo_rd(9'h100);
    st_chk(32'h0a);
    // clear, then fill across the half boundary
    cmd(32'h1);
    for (int i = 0; i < 1024; i++) fifo_wr(i[8:0]);
    st_chk(32'h02);
    fifo_wr(9'h000);
    st_chk(32'h06);
    fifo_rd(9'h000);
    st_chk(32'h02);
    for (int i = 1025; i <= 2048; i++) fifo_wr(i[8:0]);
    st_chk(32'h16);
    bus_rd(`FFX_REG_STATUS);
    chk32(rd_w & 32'h0fff_0000, 32'h0800_0000);
    n = wr_falls;
    fifo_wr(9'h1ff);
    st_chk(32'h36);
    chk32(32'(wr_falls - n), 32'h0);
    cmd(32'h2);
    st_chk(32'hb6);
    bus_wr(`FFX_REG_STATUS, 32'he0);
    // drain past the write pointer's wrap
    for (int i = 1; i <= 1023; i++) fifo_rd(i[8:0]);
    st_chk(32'h06);
    fifo_rd(9'(1024));
    st_chk(32'h02);
    for (int i = 1025; i <= 2048; i++) fifo_rd(i[8:0]);
    st_chk(32'h0a);
    // depth cascade as lead device, then as follower, then back to single mode
    bus_wr(`FFX_REG_CTRL, 32'h3);
    cmd(32'h1);
    chk1(ffx_dev_model_i.lead_r, 1'b1);
    chk1(xi_n, 1'b1);
    st_chk(32'h08);
    fifo_wr(9'h0c3);
    fifo_rd(9'h0c3);
    cmd(32'h2);
    st_chk(32'h88);
    bus_wr(`FFX_REG_STATUS, 32'h80);
    bus_wr(`FFX_REG_CTRL, 32'h1);
    cmd(32'h1);
    chk1(ffx_dev_model_i.lead_r, 1'b0);
    fifo_wr(9'h011);
    st_chk(32'h08);
    bus_wr(`FFX_REG_CTRL, 32'h2);
    cmd(32'h1);
    chk1(ffx_dev_model_i.single_r, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
